// ==== core/wd_pkg.sv ====
// Shared constants, register map and state codes of the watchdog event manager
package wd_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
    localparam int SETTLE_NS     = 30000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [2:0] ADDR_WATCHDOG_WINDOW_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_SYSTEM_CONTROL_ONE     = 3'h1;
    localparam logic [2:0] ADDR_STATUS    = 3'h2;
    localparam logic [2:0] ADDR_TALLY     = 3'h3;
    localparam logic [2:0] ADDR_LIMITS    = 3'h4;

    localparam int CFG_WINDOWED   = 4;
    localparam int SYSTEM_CONTROL_ONE_DOG_EN   = 3;
    localparam int SYSTEM_CONTROL_ONE_STBY_EN  = 2;
    localparam int SYSTEM_CONTROL_ONE_FAIL_ACT = 1;
    localparam int SYSTEM_CONTROL_ONE_RST_TYPE = 0;
    localparam int STAT_PENDING   = 0;
    localparam int STAT_IRQ       = 1;
    localparam int STAT_MASK      = 2;
    localparam int STAT_SENSE     = 3;

    localparam logic [3:0] WIN_LEN_RST     = 4'h0;
    localparam logic [2:0] EXP_LIMIT_RST   = 3'h7;
    localparam logic [3:0] EVT_LIMIT_RST   = 4'hf;
    localparam logic       IRQ_MASK_RST    = 1'b1;
    localparam logic [3:0] EXP_STEP_UP     = 4'h2;
    localparam logic [2:0] EXP_STEP_DN     = 3'h1;
    localparam logic [2:0] EXP_FIRST_LIMIT = 3'h2;
    localparam logic [2:0] EXP_TALLY_MAX   = 3'h7;
    localparam logic [3:0] EVT_TALLY_MAX   = 4'hf;

    typedef enum logic [7:0] {
        ST_OFF       = 8'h01,
        ST_RUN       = 8'h02,
        ST_SOFT      = 8'h04,
        ST_SOFT_WAIT = 8'h08,
        ST_HARD      = 8'h10,
        ST_HARD_WAIT = 8'h20,
        ST_READY     = 8'h40,
        ST_FAILSAFE  = 8'h80
    } wd_state_t;
endpackage : wd_pkg

// ==== core/wd_timer_if.sv ====
// Signals between the event manager and its refresh timer
`timescale 1ns/100ps
interface wd_timer_if;
    logic       tick;
    logic       run;
    logic       restart;
    logic [3:0] code;
    logic       expire;
    logic       first_half;

    modport ctrl (output run, output restart, output code,
                  input tick, input expire, input first_half);
    modport timer (input run, input restart, input code, input tick,
                   output expire, output first_half);
endinterface : wd_timer_if

// ==== core/ms_tick_gen.sv ====
// Millisecond enable pulse divided down from the system clock
`timescale 1ns/100ps
module ms_tick_gen #(
    parameter int CYCLES = 125000
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 32'h1;
        if (clear || cnt_r == 32'(CYCLES - 1)) begin
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = !clear && cnt_r == 32'(CYCLES - 1);
endmodule : ms_tick_gen

// ==== core/wd_refresh_timer.sv ====
// Up-counting refresh timer in millisecond steps with window position
`timescale 1ns/100ps
module wd_refresh_timer (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    wd_timer_if.timer t
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] dur;

    assign dur = 16'h0001 << t.code;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!t.run || t.restart) begin
            cnt_nxt = '0;
        end else if (t.tick) begin
            cnt_nxt = (cnt_r == dur - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign t.expire     = t.run && t.tick && cnt_r == dur - 16'h0001;
    assign t.first_half = cnt_r < (dur >> 1);
endmodule : wd_refresh_timer

// ==== core/wd_event_manager.sv ====
// Watchdog supervision: refresh timer, tallies, soft and hard resets
`timescale 1ns/100ps
//
// Contract
// - Failure pin low or expiry limit starts event
// - Pin event soft/hard by type; timer event hard
// - Timer counts up, expires at selected duration
// - Duration is two to code milliseconds
// - Timer start sets pending; host W1C refreshes
// - Timer reset off, waits host reset release
// - Window code change while on restarts timer
// - Good refresh decrements expiry tally by one
// - Expiry restarts timer, adds two to tally
// - Event when expiry tally equals expiry limit
// - Limit two or less fires on first expiry
// - Windowed mode rejects first-half refresh
// - Enable bit gates timer, guarded secure write
// - Standby enable gates timer, guarded secure write
// - Soft reset keeps host released, partial reload
// - Unkept regulators restore or turn off
// - Wait 30 us, return, raise interrupt
// - Hard reset powers down, waits, full reload
// - After reset resume per standby pin
// - Event tally increments; limit means fail-safe
// - Event tally zeroed in off states
// - Sticky interrupt flag, write one clears
module wd_event_manager
    import wd_pkg::*;
#(
    parameter int NUM_REG     = 8,
    parameter int TICK_CYC    = TICK_CYCLES
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               ext_fail_input,
    input  wire logic               standby_pin,
    input  wire logic               fail_hold_pin,
    input  wire logic               off_mode,
    input  wire logic               in_standby,
    input  wire logic               host_reset_released,
    input  wire logic               regs_settled,
    input  wire logic               pwr_down_done,
    input  wire logic               secure_guard_en,
    input  wire logic [3:0]         default_window_length,
    input  wire logic [2:0]         default_expiry_limit,
    input  wire logic [3:0]         default_event_limit,
    input  wire logic               default_dog_enable,
    input  wire logic               default_standby_dog_enable,
    input  wire logic               default_fail_standby_active,
    input  wire logic               default_reset_type,
    input  wire logic               windowed_refresh_select,
    input  wire logic [NUM_REG-1:0] keep_config_bit,
    input  wire logic [NUM_REG-1:0] reg_in_sequence,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic               reg_secure,
    input  wire logic [2:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    output logic                    irq_out_n,
    output logic                    soft_reset_busy,
    output logic                    pwr_down_req,
    output logic                    fail_safe_req,
    output logic                    partial_reload,
    output logic                    full_reload,
    output logic                    resume_req,
    output logic                    resume_standby,
    output logic      [NUM_REG-1:0] reg_restore,
    output logic      [NUM_REG-1:0] reg_turn_off
);
    wd_timer_if tmr ();

    ms_tick_gen #(.CYCLES(TICK_CYC)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (!tmr.run || tmr.restart),
        .tick    (tmr.tick)
    );

    wd_refresh_timer u_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .t       (tmr)
    );

    // Pin synchronisers: bit0 failure, bit1 standby, bit2 fail hold
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       fail_d_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r  <= 3'h7;
            sync2_r  <= 3'h7;
            fail_d_r <= 1'b1;
        end else begin
            sync1_r  <= {fail_hold_pin, standby_pin, ext_fail_input};
            sync2_r  <= sync1_r;
            fail_d_r <= sync2_r[0];
        end
    end

    wd_state_t   st_r;
    wd_state_t   st_nxt;
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    logic        boot_r;
    logic        armed_r;
    logic        hrr_d_r;
    logic        run_d_r;
    logic [3:0]  win_len_r;
    logic        dog_en_r;
    logic        stby_en_r;
    logic        fail_act_r;
    logic        rst_type_r;
    logic [2:0]  exp_limit_r;
    logic [3:0]  evt_limit_r;
    logic [2:0]  exp_tally_r;
    logic [3:0]  evt_tally_r;
    logic        pending_r;
    logic        irq_flag_r;
    logic        irq_mask_r;
    logic [7:0]  rdata_r;

    logic wr_cfg;
    logic wr_ctrl;
    logic wr_stat;
    logic guard_ok;
    logic refresh_try;
    logic refresh_ok;
    logic step_up;
    logic [3:0] up_sum;
    logic [2:0] exp_up;
    logic int_ev;
    logic ext_ev;
    logic any_ev;
    logic hard_ev;
    logic [3:0] evt_inc;
    logic safe_ev;
    logic code_chg;
    logic settle_done;
    logic do_partial;
    logic do_full;
    logic soft_done;

    assign wr_cfg   = reg_wr && reg_addr == ADDR_WATCHDOG_WINDOW_CONFIG;
    assign wr_ctrl  = reg_wr && reg_addr == ADDR_SYSTEM_CONTROL_ONE;
    assign wr_stat  = reg_wr && reg_addr == ADDR_STATUS;
    assign guard_ok = !secure_guard_en || reg_secure;

    assign tmr.code = win_len_r;
    assign tmr.run  = armed_r && dog_en_r && st_r == ST_RUN
                      && (!in_standby || stby_en_r);

    assign refresh_try = wr_stat && reg_wdata[STAT_PENDING] && pending_r
                         && tmr.run && !tmr.expire;
    assign refresh_ok  = refresh_try
                         && !(windowed_refresh_select && tmr.first_half);
    assign step_up     = tmr.expire || (refresh_try && !refresh_ok);
    assign up_sum      = {1'b0, exp_tally_r} + EXP_STEP_UP;
    assign exp_up      = (up_sum > {1'b0, EXP_TALLY_MAX}) ? EXP_TALLY_MAX : up_sum[2:0];
    assign int_ev      = step_up && (exp_up == exp_limit_r
                         || exp_limit_r <= EXP_FIRST_LIMIT);
    assign ext_ev      = st_r == ST_RUN && !sync2_r[0] && fail_d_r
                         && (!in_standby || fail_act_r);
    assign any_ev      = int_ev || ext_ev;
    assign hard_ev     = int_ev || (ext_ev && rst_type_r);
    assign evt_inc     = (evt_tally_r == EVT_TALLY_MAX) ? evt_tally_r : evt_tally_r + 4'h1;
    assign safe_ev     = any_ev && evt_inc == evt_limit_r;
    assign code_chg    = wr_cfg && reg_wdata[3:0] != win_len_r && !off_mode;
    assign settle_done = cnt_r == 12'(SETTLE_CYCLES - 1);
    assign do_partial  = any_ev && !safe_ev && !hard_ev;
    assign do_full     = boot_r || off_mode || (st_r == ST_HARD_WAIT && settle_done);
    assign soft_done   = st_r == ST_SOFT_WAIT && settle_done;
    assign tmr.restart = refresh_try || code_chg || (soft_done && armed_r);

    // Reset-sequencing state machine
    logic                resume_nxt;
    logic                resume_stby_nxt;
    logic [NUM_REG-1:0]  restore_nxt;
    logic [NUM_REG-1:0]  turn_off_nxt;
    logic                resume_r;
    logic                resume_stby_r;
    logic                partial_r;
    logic                full_r;
    logic [NUM_REG-1:0]  restore_r;
    logic [NUM_REG-1:0]  turn_off_r;

    always_comb begin
        st_nxt          = st_r;
        cnt_nxt         = '0;
        resume_nxt      = 1'b0;
        resume_stby_nxt = resume_stby_r;
        restore_nxt     = '0;
        turn_off_nxt    = '0;
        unique case (st_r)
            ST_OFF: begin
                if (!off_mode) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (off_mode) begin
                    st_nxt = ST_OFF;
                end else if (safe_ev) begin
                    st_nxt = ST_FAILSAFE;
                end else if (hard_ev) begin
                    st_nxt = ST_HARD;
                end else if (any_ev) begin
                    st_nxt       = ST_SOFT;
                    restore_nxt  = ~keep_config_bit & reg_in_sequence;
                    turn_off_nxt = ~keep_config_bit & ~reg_in_sequence;
                end
            end
            ST_SOFT: begin
                if (regs_settled) begin
                    st_nxt = ST_SOFT_WAIT;
                end
            end
            ST_SOFT_WAIT: begin
                cnt_nxt = cnt_r + 12'h001;
                if (settle_done) begin
                    st_nxt          = ST_RUN;
                    resume_nxt      = 1'b1;
                    resume_stby_nxt = sync2_r[1];
                end
            end
            ST_HARD: begin
                if (pwr_down_done) begin
                    st_nxt = ST_HARD_WAIT;
                end
            end
            ST_HARD_WAIT: begin
                cnt_nxt = cnt_r + 12'h001;
                if (settle_done) begin
                    st_nxt = ST_READY;
                end
            end
            ST_READY: begin
                if (sync2_r[2]) begin
                    st_nxt          = ST_RUN;
                    resume_nxt      = 1'b1;
                    resume_stby_nxt = sync2_r[1];
                end
            end
            ST_FAILSAFE: begin
                if (off_mode) begin
                    st_nxt = ST_OFF;
                end
            end
            default: begin
                st_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= ST_OFF;
            cnt_r         <= '0;
            resume_r      <= 1'b0;
            resume_stby_r <= 1'b0;
            partial_r     <= 1'b0;
            full_r        <= 1'b0;
            restore_r     <= '0;
            turn_off_r    <= '0;
        end else begin
            st_r          <= st_nxt;
            cnt_r         <= cnt_nxt;
            resume_r      <= resume_nxt;
            resume_stby_r <= resume_stby_nxt;
            partial_r     <= do_partial;
            full_r        <= do_full;
            restore_r     <= restore_nxt;
            turn_off_r    <= turn_off_nxt;
        end
    end

    // Register file, tallies and arming
    logic       boot_nxt;
    logic       armed_nxt;
    logic [3:0] win_len_nxt;
    logic       dog_en_nxt;
    logic       stby_en_nxt;
    logic       fail_act_nxt;
    logic       rst_type_nxt;
    logic [2:0] exp_limit_nxt;
    logic [3:0] evt_limit_nxt;
    logic [2:0] exp_tally_nxt;
    logic [3:0] evt_tally_nxt;
    logic       pending_nxt;
    logic       irq_flag_nxt;
    logic       irq_mask_nxt;
    logic [7:0] rdata_nxt;

    always_comb begin
        boot_nxt      = 1'b0;
        armed_nxt     = armed_r;
        win_len_nxt   = win_len_r;
        dog_en_nxt    = dog_en_r;
        stby_en_nxt   = stby_en_r;
        fail_act_nxt  = fail_act_r;
        rst_type_nxt  = rst_type_r;
        exp_limit_nxt = exp_limit_r;
        evt_limit_nxt = evt_limit_r;
        exp_tally_nxt = exp_tally_r;
        evt_tally_nxt = evt_tally_r;
        pending_nxt   = pending_r;
        irq_flag_nxt  = irq_flag_r;
        irq_mask_nxt  = irq_mask_r;
        rdata_nxt     = rdata_r;
        if (host_reset_released && !hrr_d_r) begin
            armed_nxt = 1'b1;
        end
        if (wr_cfg) begin
            win_len_nxt = reg_wdata[3:0];
        end
        if (wr_ctrl) begin
            if (guard_ok) begin
                dog_en_nxt  = reg_wdata[SYSTEM_CONTROL_ONE_DOG_EN];
                stby_en_nxt = reg_wdata[SYSTEM_CONTROL_ONE_STBY_EN];
            end
            fail_act_nxt = reg_wdata[SYSTEM_CONTROL_ONE_FAIL_ACT];
            rst_type_nxt = reg_wdata[SYSTEM_CONTROL_ONE_RST_TYPE];
        end
        if (wr_stat) begin
            irq_mask_nxt = reg_wdata[STAT_MASK];
            if (reg_wdata[STAT_PENDING]) begin
                pending_nxt = 1'b0;
            end
            if (reg_wdata[STAT_IRQ]) begin
                irq_flag_nxt = 1'b0;
            end
        end
        if (reg_wr && reg_addr == ADDR_TALLY) begin
            evt_tally_nxt = '0;
        end
        if (reg_wr && reg_addr == ADDR_LIMITS) begin
            exp_limit_nxt = reg_wdata[2:0];
        end
        if (refresh_ok) begin
            exp_tally_nxt = (exp_tally_r == '0) ? exp_tally_r : exp_tally_r - EXP_STEP_DN;
        end else if (step_up) begin
            exp_tally_nxt = exp_up;
        end
        if (any_ev) begin
            evt_tally_nxt = evt_inc;
            exp_tally_nxt = '0;
        end
        if (tmr.run && (tmr.restart || tmr.expire || !run_d_r)) begin
            pending_nxt = 1'b1;
        end
        if (soft_done) begin
            irq_flag_nxt = 1'b1;
        end
        if (do_partial) begin
            win_len_nxt  = default_window_length;
            dog_en_nxt   = default_dog_enable;
            stby_en_nxt  = default_standby_dog_enable;
            fail_act_nxt = default_fail_standby_active;
        end
        if (st_nxt == ST_HARD) begin
            armed_nxt = 1'b0;
        end
        if (do_full) begin
            win_len_nxt   = default_window_length;
            dog_en_nxt    = default_dog_enable;
            stby_en_nxt   = default_standby_dog_enable;
            fail_act_nxt  = default_fail_standby_active;
            rst_type_nxt  = default_reset_type;
            exp_limit_nxt = default_expiry_limit;
            evt_limit_nxt = default_event_limit;
            exp_tally_nxt = '0;
            pending_nxt   = 1'b0;
        end
        if (off_mode) begin
            armed_nxt     = 1'b0;
            evt_tally_nxt = '0;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_WATCHDOG_WINDOW_CONFIG: rdata_nxt = {3'h0, windowed_refresh_select, win_len_r};
                ADDR_SYSTEM_CONTROL_ONE:     rdata_nxt = {4'h0, dog_en_r, stby_en_r, fail_act_r, rst_type_r};
                ADDR_STATUS:    rdata_nxt = {4'h0, !sync2_r[0], irq_mask_r, irq_flag_r,
                                             pending_r};
                ADDR_TALLY:     rdata_nxt = {evt_tally_r, 1'b0, exp_tally_r};
                ADDR_LIMITS:    rdata_nxt = {evt_limit_r, 1'b0, exp_limit_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_r      <= 1'b1;
            armed_r     <= 1'b0;
            hrr_d_r     <= 1'b0;
            run_d_r     <= 1'b0;
            win_len_r   <= WIN_LEN_RST;
            dog_en_r    <= 1'b0;
            stby_en_r   <= 1'b0;
            fail_act_r  <= 1'b0;
            rst_type_r  <= 1'b0;
            exp_limit_r <= EXP_LIMIT_RST;
            evt_limit_r <= EVT_LIMIT_RST;
            exp_tally_r <= '0;
            evt_tally_r <= '0;
            pending_r   <= 1'b0;
            irq_flag_r  <= 1'b0;
            irq_mask_r  <= IRQ_MASK_RST;
            rdata_r     <= 8'h00;
        end else begin
            boot_r      <= boot_nxt;
            armed_r     <= armed_nxt;
            hrr_d_r     <= host_reset_released;
            run_d_r     <= tmr.run;
            win_len_r   <= win_len_nxt;
            dog_en_r    <= dog_en_nxt;
            stby_en_r   <= stby_en_nxt;
            fail_act_r  <= fail_act_nxt;
            rst_type_r  <= rst_type_nxt;
            exp_limit_r <= exp_limit_nxt;
            evt_limit_r <= evt_limit_nxt;
            exp_tally_r <= exp_tally_nxt;
            evt_tally_r <= evt_tally_nxt;
            pending_r   <= pending_nxt;
            irq_flag_r  <= irq_flag_nxt;
            irq_mask_r  <= irq_mask_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata       = rdata_r;
    assign irq_out_n       = !(irq_flag_r && !irq_mask_r);
    assign soft_reset_busy = st_r == ST_SOFT || st_r == ST_SOFT_WAIT;
    assign pwr_down_req    = st_r == ST_HARD || st_r == ST_HARD_WAIT || st_r == ST_READY;
    assign fail_safe_req   = st_r == ST_FAILSAFE;
    assign partial_reload  = partial_r;
    assign full_reload     = full_r;
    assign resume_req      = resume_r;
    assign resume_standby  = resume_stby_r;
    assign reg_restore     = restore_r;
    assign reg_turn_off    = turn_off_r;
endmodule : wd_event_manager

// ==== verification/wd_host_model.sv ====
// Host controller model: register cycles and failure pin
`timescale 1ns/100ps
module wd_host_model (
    input  wire logic [7:0] reg_rdata,
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            reg_secure,
    output logic [2:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            ext_fail_input
);
    initial {reg_wr, reg_rd, reg_secure, reg_addr, reg_wdata, ext_fail_input} = 15'h0001;
    // Guarded bits need s high
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic s);
        @(posedge clk_sys);
        {reg_wr, reg_secure, reg_addr, reg_wdata} <= {1'b1, s, a, d};
        @(posedge clk_sys);
        {reg_wr, reg_secure} <= 2'b00;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd
    task automatic fail_pulse();
        @(posedge clk_sys);
        ext_fail_input <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ext_fail_input <= 1'b1;
    endtask : fail_pulse
endmodule : wd_host_model

// ==== verification/wd_event_manager_chk.sv ====
// Port-level assertions of the watchdog event manager
`timescale 1ns/100ps
module wd_event_manager_chk import wd_pkg::*; #(
    parameter int NUM_REG = 8
) (
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic               off_mode,
    input wire logic               regs_settled,
    input wire logic               fail_hold_pin,
    input wire logic [NUM_REG-1:0] keep_config_bit,
    input wire logic [NUM_REG-1:0] reg_in_sequence,
    input wire logic               soft_reset_busy,
    input wire logic               pwr_down_req,
    input wire logic               fail_safe_req,
    input wire logic               partial_reload,
    input wire logic               resume_req,
    input wire logic [NUM_REG-1:0] reg_restore,
    input wire logic [NUM_REG-1:0] reg_turn_off
);
    logic [12:0] settle_r, settle_nxt;
    always_comb settle_nxt = (soft_reset_busy && regs_settled) ? settle_r + 13'h1 : 13'h0;
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            settle_r <= 13'h0;
        else
            settle_r <= settle_nxt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_soft_no_down: assert property (soft_reset_busy |-> !pwr_down_req)
        else $error("down in soft reset");
    a_soft_reload: assert property ($rose(soft_reset_busy) |-> partial_reload ##1 !partial_reload)
        else $error("reload pulse bad");
    a_settle_wait: assert property ($fell(soft_reset_busy) |-> $past(settle_r) >= SETTLE_CYCLES - 4)
        else $error("settle wait short");
    a_soft_resume: assert property ($fell(soft_reset_busy) |-> resume_req)
        else $error("no soft resume");
    a_hard_resume: assert property ($fell(pwr_down_req) |-> resume_req)
        else $error("no hard resume");
    a_hold_low: assert property (!fail_hold_pin [*4] ##0 pwr_down_req |=> pwr_down_req)
        else $error("left hold early");
    a_failsafe_alone: assert property (fail_safe_req |-> !soft_reset_busy && !pwr_down_req)
        else $error("fail-safe in reset");
    a_off_exit: assert property (fail_safe_req && off_mode |-> ##[1:2] !fail_safe_req)
        else $error("fail-safe kept");
    a_keep_config: assert property (|reg_restore |->
        (reg_restore & ($past(keep_config_bit) | ~$past(reg_in_sequence))) == '0)
        else $error("bad restore");
    a_turn_off: assert property (|reg_turn_off |->
        (reg_turn_off & ($past(keep_config_bit) | $past(reg_in_sequence))) == '0)
        else $error("bad turn off");
endmodule : wd_event_manager_chk
bind wd_event_manager wd_event_manager_chk #(.NUM_REG(NUM_REG)) u_wd_event_manager_chk (.*);

// ==== verification/wd_event_manager_tb_top.sv ====
// Bench of the watchdog event manager
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module wd_event_manager_tb_top import wd_pkg::*; ;
    int n_mismatch = 0, tests_run = 0;
    logic clk_sys = 1'b0, rst_n = 1'b0, standby_pin = 1'b0, fail_hold_pin = 1'b1;
    logic off_mode = 1'b0, in_standby = 1'b0, host_reset_released = 1'b0;
    logic regs_settled = 1'b1, pwr_down_done = 1'b0, secure_guard_en = 1'b1;
    logic default_dog_enable = 1'b0, default_standby_dog_enable = 1'b0;
    logic default_fail_standby_active = 1'b0, default_reset_type = 1'b0;
    logic windowed_refresh_select = 1'b0;
    logic [3:0] default_window_length = 4'h3, default_event_limit = 4'h3;
    logic [2:0] default_expiry_limit = 3'h7, reg_addr;
    logic [7:0] keep_config_bit = 8'h0f, reg_in_sequence = 8'h33, reg_wdata, reg_rdata, d;
    logic [7:0] reg_restore, reg_turn_off;
    logic reg_wr, reg_rd, reg_secure, ext_fail_input, irq_out_n, soft_reset_busy;
    logic pwr_down_req, fail_safe_req, partial_reload, full_reload, resume_req, resume_standby;
    wd_event_manager #(.TICK_CYC(10)) u_wd_event_manager (.*);
    wd_host_model u_wd_host_model (.*);
    initial forever #4 clk_sys = ~clk_sys;
    task automatic results();
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic wait_hi(ref logic s, input int lim);
        int n = 0;
        do @(posedge clk_sys); while (s !== 1'b1 && ++n < lim);
        `CHK(s, 1'b1)
    endtask : wait_hi
    task automatic rc(input logic [2:0] a, input logic [7:0] m, e);
        u_wd_host_model.rd(a, d);
        `CHK(d & m, e)
    endtask : rc
    task automatic t_regs();
        rc(ADDR_STATUS, 8'hff, 8'h04);
        rc(ADDR_LIMITS, 8'hff, 8'h37);
        rc(ADDR_WATCHDOG_WINDOW_CONFIG, 8'hff, 8'h03);
        rc(3'h5, 8'hff, 8'h00);
        u_wd_host_model.wr(ADDR_SYSTEM_CONTROL_ONE, 8'h0e, 1'b0);
        rc(ADDR_SYSTEM_CONTROL_ONE, 8'hff, 8'h02);
    endtask : t_regs
    task automatic t_soft();
        u_wd_host_model.fail_pulse();
        wait_hi(partial_reload, 20);
        `CHK(reg_restore, ~keep_config_bit & reg_in_sequence)
        `CHK(reg_turn_off, ~keep_config_bit & ~reg_in_sequence)
        `CHK({soft_reset_busy, pwr_down_req}, 2'b10)
        wait_hi(resume_req, 5000);
        `CHK(resume_standby, 1'b0)
        rc(ADDR_STATUS, 8'h06, 8'h06);
        `CHK(irq_out_n, 1'b1)
        u_wd_host_model.wr(ADDR_STATUS, 8'h00, 1'b0);
        @(posedge clk_sys);
        `CHK(irq_out_n, 1'b0)
        u_wd_host_model.wr(ADDR_STATUS, 8'h06, 1'b0);
        @(posedge clk_sys);
        `CHK(irq_out_n, 1'b1)
        rc(ADDR_TALLY, 8'hf0, 8'h10);
    endtask : t_soft
    task automatic t_timer();
        u_wd_host_model.wr(ADDR_SYSTEM_CONTROL_ONE, 8'h08, 1'b1);
        rc(ADDR_STATUS, 8'h01, 8'h01);
        u_wd_host_model.wr(ADDR_WATCHDOG_WINDOW_CONFIG, 8'h02, 1'b0);
        for (int i = 0; i < 4; i++) begin
            repeat (i ? 37 : 17) @(posedge clk_sys);
            rc(ADDR_TALLY, 8'h07, 8'(2 * i));
        end
        u_wd_host_model.wr(ADDR_STATUS, 8'h05, 1'b0);
        rc(ADDR_TALLY, 8'h07, 8'h05);
        wait_hi(pwr_down_req, 60);
    endtask : t_timer
    task automatic t_hard();
        {fail_hold_pin, standby_pin, pwr_down_done} <= 3'h3;
        wait_hi(full_reload, 5000);
        repeat (20) @(posedge clk_sys);
        `CHK(pwr_down_req, 1'b1)
        fail_hold_pin <= 1'b1;
        wait_hi(resume_req, 20);
        `CHK(resume_standby, 1'b1)
        pwr_down_done <= 1'b0;
        rc(ADDR_TALLY, 8'hf0, 8'h20);
    endtask : t_hard
    task automatic t_failsafe();
        u_wd_host_model.fail_pulse();
        wait_hi(fail_safe_req, 10);
        `CHK({soft_reset_busy, pwr_down_req}, 2'b00)
        {off_mode, host_reset_released} <= 2'h2;
        repeat (3) @(posedge clk_sys);
        `CHK(fail_safe_req, 1'b0)
        off_mode <= 1'b0;
        rc(ADDR_TALLY, 8'hf0, 8'h00);
    endtask : t_failsafe
    initial begin
        #400us;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host_reset_released <= 1'b1;
        t_regs();
        t_soft();
        t_timer();
        t_hard();
        t_failsafe();
        results();
    end
endmodule : wd_event_manager_tb_top
